// ---- hdl/motion_ctrl_serial_ports.sv ----
// Contract
// - driver datagrams built and sent autonomously
// - datagram layout separately set per driver
// - 5-bit codes pick bits, ram order
// - 6-bit word: next-motor flag plus code
// - last driver index sets chain length
// - driver clock period 16 to 512 cycles
// - default driver clock 16 low 16 high
// - shortest driver clock 8 low 8 high
// - driver select and clock polarity programmable
// - host output bit 2-3 cycles after fall
// - idle output returns within 4.5 cycles
// - host frames 32 bits, msb first
// - reply shifted out during request frame
// - request: select, address, read flag, data
// - read flag 1 reads, 0 writes
// - reply: status 31-24, data 23-0
// - short registers use part of data
// - every reply carries status bits
// - idle host output is interrupt status low
// - shift on sck rise, latch on select rise
// - reset clears all, prediv starts at 15, tx pointer at 31; code sets host output, driver clock level and sck/select syncs high
module motion_ctrl_serial_ports
    import motion_serial_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        host_sck_i,
    input  wire logic                        host_chip_select_n_i,
    input  wire logic                        host_serial_in_i,
    output logic                             host_serial_out_o,
    input  wire logic                        irq_status_low_i,
    input  wire logic [STATUS_W-1:0]         status_i,
    output logic [ADDR_W-1:0]                rd_addr_o,
    output logic                             rd_reg_ram_select_o,
    input  wire logic [DATA_W-1:0]           rd_data_i,
    output logic                             req_valid_o,
    output logic                             req_reg_ram_select_o,
    output logic [ADDR_W-1:0]                req_addr_o,
    output logic                             req_read_o,
    output logic [DATA_W-1:0]                req_data_o,
    input  wire logic [MOTOR_W-1:0]          last_driver_index_i,
    input  wire logic [PREDIV_W-1:0]         drv_clock_prediv_i,
    input  wire logic                        drv_clock_prediv_we_i,
    input  wire logic                        drv_cs_invert_i,
    input  wire logic                        drv_sck_invert_i,
    input  wire logic [MOTORS*PRIM_BITS-1:0] prim_signals_i,
    input  wire logic                        send_req_i,
    output logic                             drv_chip_select_n_o,
    output logic                             drv_sck_o,
    output logic                             drv_serial_out_o,
    input  wire logic                        drv_serial_in_i,
    output logic [DRV_REPLY_W-1:0]           drv_reply_o,
    output logic                             drv_busy_o,
    output logic                             drv_done_o
);
    // host side synchronisers; first stages feed only the second
    logic                   sck_meta_reg,  sck_s1_reg,  sck_s2_reg;
    logic                   cs_meta_reg,   cs_s1_reg,   cs_s2_reg;
    logic                   sdi_meta_reg,  sdi_s1_reg;
    logic [HOST_FRAME_BITS-1:0] rx_shift_reg;
    logic [HOST_FRAME_BITS-1:0] reply_reg;
    logic [5:0]             rx_count_reg;
    logic [4:0]             tx_ptr_reg;
    logic                   out_reg;
    logic                   fetch_reg;
    logic [CFG_W-1:0]       cfg_ram [CFG_ENTRIES];

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sck_meta_reg <= 1'b1;
            sck_s1_reg   <= 1'b1;
            sck_s2_reg   <= 1'b1;
            cs_meta_reg  <= 1'b1;
            cs_s1_reg    <= 1'b1;
            cs_s2_reg    <= 1'b1;
            sdi_meta_reg <= 1'b0;
            sdi_s1_reg   <= 1'b0;
        end else begin
            sck_meta_reg <= host_sck_i;
            sck_s1_reg   <= sck_meta_reg;
            sck_s2_reg   <= sck_s1_reg;
            cs_meta_reg  <= host_chip_select_n_i;
            cs_s1_reg    <= cs_meta_reg;
            cs_s2_reg    <= cs_s1_reg;
            sdi_meta_reg <= host_serial_in_i;
            sdi_s1_reg   <= sdi_meta_reg;
        end
    end

    wire sck_rise   = sck_s1_reg & ~sck_s2_reg;
    wire sck_fall   = ~sck_s1_reg & sck_s2_reg;
    wire cs_fall    = ~cs_s1_reg & cs_s2_reg;
    wire cs_rise    = cs_s1_reg & ~cs_s2_reg;
    wire in_frame   = ~cs_s1_reg;
    wire frame_full = (rx_count_reg == HOST_BITS_FULL);

    // read address known after 8 bits; data fetched one cycle later
    wire [ADDR_W-1:0] live_addr = rx_shift_reg[ADDR_MSB-ADDR_LSB+1:1];
    wire              live_rrs  = rx_shift_reg[ADDR_W+1];
    wire              rd_cfg    = rd_reg_ram_select_o & ~rd_addr_o[CFG_AREA_BIT];
    wire [CFG_IDX_W-1:0] rd_even = {rd_addr_o[CFG_AREA_BIT-1:0], 1'b0};
    wire [CFG_IDX_W-1:0] rd_odd  = {rd_addr_o[CFG_AREA_BIT-1:0], 1'b1};
    wire [DATA_W-1:0] cfg_rd_word = {{(DATA_W-2*CFG_W){1'b0}}, cfg_ram[rd_odd], cfg_ram[rd_even]};
    wire [DATA_W-1:0] rd_word   = rd_cfg ? cfg_rd_word : rd_data_i;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rx_shift_reg        <= '0;
            rx_count_reg        <= '0;
            reply_reg           <= '0;
            tx_ptr_reg          <= HOST_PTR_MSB;
            out_reg             <= 1'b1;
            fetch_reg           <= 1'b0;
            rd_addr_o           <= '0;
            rd_reg_ram_select_o <= 1'b0;
        end else begin
            fetch_reg <= 1'b0;
            if (cs_fall) begin
                rx_count_reg <= '0;
                tx_ptr_reg   <= HOST_PTR_MSB;
                reply_reg    <= {irq_status_low_i, status_i, {DATA_W{1'b0}}};
            end
            if (in_frame && sck_rise && !frame_full) begin
                rx_shift_reg <= {rx_shift_reg[HOST_FRAME_BITS-2:0], sdi_s1_reg};
                rx_count_reg <= rx_count_reg + 6'h01;
                if (rx_count_reg == HOST_BITS_ADDR - 6'h01) begin
                    fetch_reg <= 1'b1;
                end
            end
            if (fetch_reg) begin
                rd_addr_o           <= live_addr;
                rd_reg_ram_select_o <= live_rrs;
            end
            if (in_frame && rx_count_reg == HOST_BITS_ADDR && !fetch_reg && sck_s1_reg) begin
                reply_reg[DATA_MSB:0] <= rd_word;
            end
            if (in_frame && sck_fall) begin
                out_reg    <= reply_reg[tx_ptr_reg];
                tx_ptr_reg <= tx_ptr_reg - 5'h01;
            end else if (!in_frame) begin
                out_reg <= irq_status_low_i;
            end
        end
    end

    assign host_serial_out_o = out_reg;

    // request taken only for complete frames on select rise
    wire              req_fire = cs_rise & frame_full;
    wire              req_rrs  = rx_shift_reg[RRS_BIT];
    wire [ADDR_W-1:0] req_addr = rx_shift_reg[ADDR_MSB:ADDR_LSB];
    wire              req_rd   = rx_shift_reg[RW_BIT];
    wire              cfg_wr   = req_fire & req_rrs & ~req_addr[CFG_AREA_BIT] & ~req_rd;
    wire [CFG_IDX_W-1:0] wr_even = {req_addr[CFG_AREA_BIT-1:0], 1'b0};
    wire [CFG_IDX_W-1:0] wr_odd  = {req_addr[CFG_AREA_BIT-1:0], 1'b1};

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            req_valid_o          <= 1'b0;
            req_reg_ram_select_o <= 1'b0;
            req_addr_o           <= '0;
            req_read_o           <= 1'b0;
            req_data_o           <= '0;
        end else begin
            req_valid_o <= req_fire & ~cfg_wr;
            // internal ram writes leave the forwarded request standing
            if (req_fire && !cfg_wr) begin
                req_reg_ram_select_o <= req_rrs;
                req_addr_o           <= req_addr;
                req_read_o           <= req_rd;
                // data of a read is don't care; forwarded as zero
                req_data_o           <= req_rd ? '0 : rx_shift_reg[DATA_MSB:0];
            end
        end
    end

    // configuration ram; two 6-bit entries per host address
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < CFG_ENTRIES; i++) begin
                cfg_ram[i] <= '0;
            end
        end else if (cfg_wr) begin
            cfg_ram[wr_even] <= rx_shift_reg[CFG_W-1:0];
            cfg_ram[wr_odd]  <= rx_shift_reg[CFG_ODD_LSB+CFG_W-1:CFG_ODD_LSB];
        end
    end

    // driver clock pre-divider, clamped so a half period is never under 8
    logic [PREDIV_W-1:0] prediv_reg;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prediv_reg <= PREDIV_RESET;
        end else if (drv_clock_prediv_we_i) begin
            prediv_reg <= drv_clock_prediv_i;
        end
    end
    wire [PREDIV_W-1:0] half_load = (prediv_reg < PREDIV_MIN) ? PREDIV_MIN : prediv_reg;

    // driver datagram engine
    drv_state_e              state_reg;
    logic [PREDIV_W-1:0]     cnt_reg;
    logic [CFG_IDX_W-1:0]    entry_reg;
    logic [MOTOR_W-1:0]      motor_reg;
    logic                    pending_reg;
    logic                    cs_act_reg;
    logic                    sck_lvl_reg;
    logic                    sdo_reg;
    logic [DRV_REPLY_W-1:0]  drv_reply_reg;
    logic                    done_reg;

    wire [PRIM_PAD_W-1:0]  prim_pad  = {{(PRIM_PAD_W-MOTORS*PRIM_BITS){1'b0}}, prim_signals_i};
    wire [CFG_W-1:0]       cur_word  = cfg_ram[entry_reg];
    wire                   cur_nxm   = cur_word[NEXT_MOTOR_FLAG];
    wire                   last_bit  = (cur_nxm && motor_reg == last_driver_index_i)
                                       || entry_reg == CFG_LAST_ENTRY;
    wire [CFG_IDX_W-1:0]   nxt_entry = entry_reg + 6'h01;
    wire [MOTOR_W-1:0]     nxt_motor = motor_reg + {1'b0, cur_nxm};
    wire [CFG_W-1:0]       nxt_word  = cfg_ram[nxt_entry];
    wire                   nxt_bit   = prim_pad[{nxt_motor, nxt_word[CODE_W-1:0]}];
    wire                   first_bit = prim_pad[{{MOTOR_W{1'b0}}, cfg_ram[0][CODE_W-1:0]}];
    wire                   cnt_done  = (cnt_reg == '0);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_reg     <= DRV_IDLE;
            cnt_reg       <= '0;
            entry_reg     <= '0;
            motor_reg     <= '0;
            pending_reg   <= 1'b0;
            cs_act_reg    <= 1'b0;
            sck_lvl_reg   <= 1'b1;
            sdo_reg       <= 1'b0;
            drv_reply_reg <= '0;
            done_reg      <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (send_req_i) begin
                pending_reg <= 1'b1;
            end
            if (state_reg != DRV_IDLE && !cnt_done) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
            unique case (state_reg)
                DRV_IDLE: begin
                    // a request during a datagram is merged into one more
                    if (pending_reg) begin
                        pending_reg <= send_req_i;
                        state_reg   <= DRV_SETUP;
                        cs_act_reg  <= 1'b1;
                        cnt_reg     <= half_load;
                        entry_reg   <= '0;
                        motor_reg   <= '0;
                    end
                end
                DRV_SETUP: if (cnt_done) begin
                    state_reg   <= DRV_LOW;
                    sck_lvl_reg <= 1'b0;
                    sdo_reg     <= first_bit;
                    cnt_reg     <= half_load;
                end
                DRV_LOW: if (cnt_done) begin
                    state_reg     <= DRV_HIGH;
                    sck_lvl_reg   <= 1'b1;
                    drv_reply_reg <= {drv_reply_reg[DRV_REPLY_W-2:0], drv_serial_in_i};
                    cnt_reg       <= half_load;
                end
                DRV_HIGH: if (cnt_done) begin
                    cnt_reg <= half_load;
                    if (last_bit) begin
                        state_reg <= DRV_HOLD;
                    end else begin
                        state_reg   <= DRV_LOW;
                        sck_lvl_reg <= 1'b0;
                        sdo_reg     <= nxt_bit;
                        entry_reg   <= nxt_entry;
                        motor_reg   <= nxt_motor;
                    end
                end
                DRV_HOLD: if (cnt_done) begin
                    state_reg  <= DRV_GAP;
                    cs_act_reg <= 1'b0;
                    cnt_reg    <= half_load;
                    done_reg   <= 1'b1;
                end
                DRV_GAP: if (cnt_done) begin
                    state_reg <= DRV_IDLE;
                end
                default: state_reg <= DRV_IDLE;
            endcase
        end
    end

    assign drv_chip_select_n_o = ~cs_act_reg ^ drv_cs_invert_i;
    assign drv_sck_o           = sck_lvl_reg ^ drv_sck_invert_i;
    assign drv_serial_out_o    = sdo_reg;
    assign drv_reply_o         = drv_reply_reg;
    assign drv_busy_o          = (state_reg != DRV_IDLE);
    assign drv_done_o          = done_reg;
endmodule : motion_ctrl_serial_ports

// ---- hdl/motion_serial_pkg.sv ----
package motion_serial_pkg;
    // host frame layout
    localparam int          HOST_FRAME_BITS = 32;
    localparam logic [5:0]  HOST_BITS_FULL  = 6'h20;
    localparam logic [5:0]  HOST_BITS_ADDR  = 6'h08;
    localparam logic [4:0]  HOST_PTR_MSB    = 5'h1f;
    localparam int          RRS_BIT         = 31;
    localparam int          ADDR_MSB        = 30;
    localparam int          ADDR_LSB        = 25;
    localparam int          RW_BIT          = 24;
    localparam int          DATA_MSB        = 23;
    localparam int          STATUS_LSB      = 24;
    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 24;
    localparam int          STATUS_W        = 7;

    // driver chain configuration ram
    localparam int          CFG_ENTRIES     = 64;
    localparam int          CFG_IDX_W       = 6;
    localparam int          CFG_W           = 6;
    localparam int          CODE_W          = 5;
    localparam int          NEXT_MOTOR_FLAG         = 5;
    localparam int          CFG_AREA_BIT    = 5;
    localparam int          CFG_ODD_LSB     = 6;
    localparam logic [5:0]  CFG_LAST_ENTRY  = 6'h3f;
    localparam int          MOTORS          = 3;
    localparam int          MOTOR_W         = 2;
    localparam int          PRIM_BITS       = 32;
    localparam int          PRIM_PAD_W      = 128;

    // driver clock: half period = max(prediv, 7) + 1 system clocks
    localparam int          PREDIV_W        = 8;
    localparam logic [7:0]  PREDIV_RESET    = 8'h0f;
    localparam logic [7:0]  PREDIV_MIN      = 8'h07;
    localparam int          DRV_REPLY_W     = 32;

    typedef enum logic [2:0] {
        DRV_IDLE  = 3'h0,
        DRV_SETUP = 3'h1,
        DRV_LOW   = 3'h3,
        DRV_HIGH  = 3'h2,
        DRV_HOLD  = 3'h6,
        DRV_GAP   = 3'h7
    } drv_state_e;
endpackage : motion_serial_pkg

// ---- tb/motion_ctrl_serial_ports_monitor.sv ----
module motion_ctrl_serial_ports_monitor
    import motion_serial_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                reset_n_i,
    input wire logic                host_sck_i,
    input wire logic                host_chip_select_n_i,
    input wire logic                host_serial_out_o,
    input wire logic                irq_status_low_i,
    input wire logic                req_valid_o,
    input wire logic                req_reg_ram_select_o,
    input wire logic [ADDR_W-1:0]   req_addr_o,
    input wire logic                req_read_o,
    input wire logic [DATA_W-1:0]   req_data_o,
    input wire logic [PREDIV_W-1:0] drv_clock_prediv_i,
    input wire logic                drv_clock_prediv_we_i,
    input wire logic                drv_cs_invert_i,
    input wire logic                drv_sck_invert_i,
    input wire logic                drv_chip_select_n_o,
    input wire logic                drv_sck_o,
    input wire logic                drv_busy_o,
    input wire logic                drv_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [PREDIV_W-1:0] prediv_reg;
    logic [1:0]          pair_reg;
    logic [9:0]          run_reg;
    wire logic           cs_act = ~(drv_chip_select_n_o ^ drv_cs_invert_i);
    wire logic [9:0]     half   = (prediv_reg < PREDIV_MIN) ? 10'h8 : {2'h0, prediv_reg} + 10'h1;
    // shadow divider, so the phase check follows reloads made at run time
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prediv_reg <= PREDIV_RESET;
            pair_reg   <= 2'h3;
            run_reg    <= 10'h0;
        end else begin
            if (drv_clock_prediv_we_i) begin
                prediv_reg <= drv_clock_prediv_i;
            end
            pair_reg <= {drv_chip_select_n_o, drv_sck_o};
            run_reg  <= (pair_reg != {drv_chip_select_n_o, drv_sck_o}) ? 10'h1 : run_reg + 10'h1;
        end
    end
    sequence s_sel_idle; host_chip_select_n_i [*5]; endsequence
    sequence s_sel_busy; !host_chip_select_n_i [*5]; endsequence
    property p_sck_phase; cs_act && $past(cs_act) && $changed(drv_sck_o) |-> run_reg == half; endproperty
    a_sck_phase: assert property (p_sck_phase) else $error("driver clock phase length wrong");
    property p_idle_pol;
        !drv_busy_o && $stable(drv_cs_invert_i) && $stable(drv_sck_invert_i)
            |-> drv_chip_select_n_o == !drv_cs_invert_i && drv_sck_o == !drv_sck_invert_i;
    endproperty
    a_idle_pol: assert property (p_idle_pol) else $error("driver idle levels wrong");
    property p_done; drv_done_o |-> !cs_act ##1 !drv_done_o; endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
    property p_req_hold; !req_valid_o |-> $stable({req_reg_ram_select_o, req_addr_o, req_read_o, req_data_o}); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request changed without valid");
    property p_read_zero; req_valid_o && req_read_o |-> req_data_o == 24'h0; endproperty
    a_read_zero: assert property (p_read_zero) else $error("read data field not ignored");
    property p_idle_out; s_sel_idle |-> host_serial_out_o == $past(irq_status_low_i); endproperty
    a_idle_out: assert property (p_idle_out) else $error("idle output not irq");
    property p_idle_ret; $rose(host_chip_select_n_i) |-> ##[1:4] host_serial_out_o == $past(irq_status_low_i); endproperty
    a_idle_ret: assert property (p_idle_ret) else $error("irq not back in time");
    property p_bit_time; s_sel_busy ##0 $changed(host_serial_out_o) |-> !$past(host_sck_i) && !$past(host_sck_i, 2); endproperty
    a_bit_time: assert property (p_bit_time) else $error("reply bit moved off sck fall");
endmodule : motion_ctrl_serial_ports_monitor

bind motion_ctrl_serial_ports motion_ctrl_serial_ports_monitor motion_ctrl_serial_ports_monitor_inst (
    .clk_i, .reset_n_i, .host_sck_i, .host_chip_select_n_i, .host_serial_out_o, .irq_status_low_i,
    .req_valid_o, .req_reg_ram_select_o, .req_addr_o, .req_read_o, .req_data_o, .drv_clock_prediv_i,
    .drv_clock_prediv_we_i, .drv_cs_invert_i, .drv_sck_invert_i, .drv_chip_select_n_o, .drv_sck_o,
    .drv_busy_o, .drv_done_o
);

// ---- tb/drv_chain_model.sv ----
module drv_chain_model (
    input  wire logic   clk_i,
    input  wire logic   cs_n_i,
    input  wire logic   sck_i,
    input  wire logic   cs_invert_i,
    input  wire logic   sck_invert_i,
    input  wire logic   sdo_i,
    output logic        sdi_o,
    output logic [31:0] rx_o,
    output logic [7:0]  count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] tx_reg  = 32'h0;
    logic        sck_reg = 1'b1;
    logic        act_reg = 1'b0;
    wire logic   act     = ~(cs_n_i ^ cs_invert_i);
    wire logic   sck     = sck_i ^ sck_invert_i;
    initial begin
        sdi_o   = 1'b0;
        rx_o    = 32'h0;
        count_o = 8'h0;
    end
    always @(posedge clk_i) begin
        act_reg <= act;
        sck_reg <= sck;
        if (act && !act_reg) begin
            tx_reg  <= 32'hc35a_0f96;
            sdi_o   <= 1'b1;
            rx_o    <= 32'h0;
            count_o <= 8'h0;
        end else if (!act) begin
            sdi_o <= 1'b0; // released line rests on its pull-down
        end else if (sck && !sck_reg) begin
            rx_o    <= {rx_o[30:0], sdo_i};
            count_o <= count_o + 8'h1;
        end else if (!sck && sck_reg && count_o != 8'h0) begin
            tx_reg <= {tx_reg[30:0], 1'b0};
            sdi_o  <= tx_reg[30];
        end
    end
endmodule : drv_chain_model

// ---- tb/tb_motion_ctrl_serial_ports.sv ----
module tb_motion_ctrl_serial_ports
    import motion_serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, reset_n_i = 1'b0, host_sck_i = 1'b1, host_chip_select_n_i = 1'b1, host_serial_in_i = 1'b0;
    logic irq_status_low_i = 1'b1, send_req_i = 1'b0, drv_clock_prediv_we_i = 1'b0;
    logic drv_cs_invert_i = 1'b0, drv_sck_invert_i = 1'b0;
    logic [STATUS_W-1:0]         status_i = 7'h15;
    logic [MOTOR_W-1:0]          last_driver_index_i = 2'h2;
    logic [PREDIV_W-1:0]         drv_clock_prediv_i = 8'h0f;
    logic [MOTORS*PRIM_BITS-1:0] prim_signals_i = 96'ha000_0000_0000_0002_0000_0148;
    logic host_serial_out_o, rd_reg_ram_select_o, req_valid_o, req_reg_ram_select_o, req_read_o, drv_done_o;
    logic drv_chip_select_n_o, drv_sck_o, drv_serial_out_o, drv_serial_in_i, drv_busy_o;
    logic [ADDR_W-1:0]      rd_addr_o, req_addr_o;
    logic [DATA_W-1:0]      req_data_o;
    logic [DRV_REPLY_W-1:0] drv_reply_o;
    logic [31:0]            chain_rx;
    logic [7:0]             chain_count;
    int                     bad_count = 0, tests_run = 0;
    wire logic [DATA_W-1:0] rd_data_i = {rd_reg_ram_select_o, rd_addr_o, 17'h0a5c3};
    wire logic [31:0]       req_word  = {req_reg_ram_select_o, req_addr_o, req_read_o, req_data_o};

    motion_ctrl_serial_ports motion_ctrl_serial_ports_inst (
        .clk_i, .reset_n_i, .host_sck_i, .host_chip_select_n_i, .host_serial_in_i, .host_serial_out_o,
        .irq_status_low_i, .status_i, .rd_addr_o, .rd_reg_ram_select_o, .rd_data_i, .req_valid_o,
        .req_reg_ram_select_o, .req_addr_o, .req_read_o, .req_data_o, .last_driver_index_i, .drv_clock_prediv_i,
        .drv_clock_prediv_we_i, .drv_cs_invert_i, .drv_sck_invert_i, .prim_signals_i, .send_req_i,
        .drv_chip_select_n_o, .drv_sck_o, .drv_serial_out_o, .drv_serial_in_i, .drv_reply_o, .drv_busy_o, .drv_done_o
    );
    drv_chain_model drv_chain_model_inst (
        .clk_i, .cs_n_i(drv_chip_select_n_o), .sck_i(drv_sck_o), .cs_invert_i(drv_cs_invert_i),
        .sck_invert_i(drv_sck_invert_i), .sdo_i(drv_serial_out_o), .sdi_o(drv_serial_in_i), .rx_o(chain_rx),
        .count_o(chain_count)
    );

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // 4 cycles per sck phase and select margin keeps clear of the 3-cycle minimum
    task automatic host_xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx, output logic got);
        rx  = 32'h0;
        got = 1'b0;
        host_chip_select_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            host_sck_i       <= 1'b0;
            host_serial_in_i <= tx[31-i];
            repeat (4) @(posedge clk_i);
            rx = {rx[30:0], host_serial_out_o};
            host_sck_i <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        host_chip_select_n_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            got = got | (req_valid_o === 1'b1);
        end
    endtask : host_xfer

    task automatic wait_busy(input logic level, input int limit);
        for (int n = 0; drv_busy_o !== level; n++) begin
            if (n > limit) begin
                bad_count++;
                $display("unexpected at %0t: busy wait expired", $time);
                end_of_test();
            end
            @(posedge clk_i);
        end
    endtask : wait_busy

    task automatic t_write();
        logic [31:0] rx;
        logic        got;
        host_xfer(32'h1a00_0123, 32, rx, got);
        check({31'h0, got}, 32'h1);
        check(req_word, 32'h1a00_0123);
        check({24'h0, rx[31:24]}, {24'h0, irq_status_low_i, status_i});
        $display("write frame test done");
    endtask : t_write

    task automatic t_read();
        logic [31:0] rx;
        logic        got;
        irq_status_low_i <= 1'b0;
        status_i         <= 7'h6a;
        host_xfer(32'h55ab_cdef, 32, rx, got);
        check(req_word, 32'h5500_0000);
        check(rx, {1'b0, 7'h6a, 1'b0, 6'h2a, 17'h0a5c3});
        check({31'h0, host_serial_out_o}, 32'h0);
        irq_status_low_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        check({31'h0, host_serial_out_o}, 32'h1);
        $display("read frame test done");
    endtask : t_read

    task automatic t_short();
        logic [31:0] rx;
        logic        got;
        host_xfer(32'h1a00_0456, 31, rx, got);
        check({31'h0, got}, 32'h0);
        check(req_word, 32'h5500_0000);
        $display("short frame test done");
    endtask : t_short

    task automatic t_chain();
        logic [31:0] rx;
        logic        got;
        host_xfer(32'h8000_09c3, 32, rx, got);
        host_xfer(32'h8200_0fa1, 32, rx, got);
        host_xfer(32'h8100_0000, 32, rx, got);
        check({20'h0, rx[11:0]}, 32'h9c3);
        // default divider first, then the clamped minimum inverted, then the slowest setting
        for (int k = 0; k < 3; k++) begin
            drv_cs_invert_i       <= (k == 1);
            drv_sck_invert_i      <= (k == 1);
            drv_clock_prediv_i    <= (k == 1) ? 8'h03 : 8'hff;
            drv_clock_prediv_we_i <= (k != 0);
            @(posedge clk_i);
            drv_clock_prediv_we_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            send_req_i <= 1'b1;
            @(posedge clk_i);
            send_req_i <= 1'b0;
            wait_busy(1'b1, 8);
            wait_busy(1'b0, 12000);
            check({24'h0, chain_count}, 32'h4);
            check({28'h0, chain_rx[3:0]}, 32'ha);
            check({28'h0, drv_reply_o[3:0]}, 32'hc);
        end
        $display("driver chain test done");
    endtask : t_chain

    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_write();
        t_read();
        t_short();
        t_chain();
        end_of_test();
    end
endmodule : tb_motion_ctrl_serial_ports
